// ### src/ast_pkg.sv
package ast_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_PORT_CTRL = 8'h18;
  localparam logic [7:0] OFS_TX_BUFFER = 8'h19;
  localparam logic [7:0] OFS_ENABLES = 8'h8c;
  localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h99;
  // Field positions
  localparam int BIT_CLOCK_SOURCE = 7;
  localparam int BIT_NINE_BIT_SELECT = 6;
  localparam int BIT_TRANSMIT_ENABLE = 5;
  localparam int BIT_SYNC_SELECT = 4;
  localparam int BIT_HIGH_SPEED_SELECT = 2;
  localparam int BIT_SHIFTER_EMPTY = 1;
  localparam int BIT_NINTH_DATA_BIT = 0;
  localparam int BIT_PORT_ENABLE = 7;
  localparam int BIT_TX_BUFFER_EMPTY = 4;
  localparam int BIT_TX_INTERRUPT_ENABLE = 4;
  // Reset values
  localparam logic [7:0] RST_TX_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_PORT_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_BUFFER = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  // Baud generator ticks per bit, less one (16 or 64 ticks), and data bits per frame
  localparam logic [5:0] TICKS_HIGH_SPEED = 6'h0f;
  localparam logic [5:0] TICKS_LOW_SPEED = 6'h3f;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_START = 3'b011,
    ST_DATA = 3'b010,
    ST_STOP = 3'b110
  } ast_state_e;

  typedef struct packed {
    logic clock_source;
    logic nine_bit_select;
    logic transmit_enable;
    logic sync_select;
    logic high_speed_select;
    logic ninth_data_bit;
  } ast_ctrl_s;
endpackage

// ### src/ast_transmitter.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Frame is NRZ: start bit, eight or nine data bits, one stop bit.
// - Data bits go out least significant bit first.
// - Transmitter runs independently; frame format and baud shared with receiver.
// - Dedicated 8-bit baud generator divides the clock.
// - Generator runs at 16x bit rate on high speed, else 64x.
// - Baud is clock/(64(X+1)) low speed, clock/(16(X+1)) high speed.
// - Writing the divisor clears the baud generator timer at once.
// - No parity hardware; software may send parity as ninth bit.
// - Asynchronous operation halts during sleep.
// - Asynchronous mode when sync select, control bit 4, is clear.
// - Shifter reloads only after stop bit, immediately if buffer full.
// - Buffer to shifter move takes one cycle, then empty flag rises.
// - Empty flag sets regardless of enable; only buffer write clears it.
// - Interrupt request passes only while interrupt enable bit 4 set.
// - Read-only shifter empty bit 1 set when shifter empty; no interrupt.
// - Shift register is not software accessible.
// - Setting transmit enable sets the buffer empty flag.
// - Character starts once buffer has data and a shift clock occurs.
// - Loading buffer then setting enable also starts transmission.
// - Write to empty shifter transfers at once, freeing buffer again.
// - Clearing enable aborts, resets transmitter, pin goes high impedance.
module ast_transmitter #(
  parameter int DIV_W = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SLEEP,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic TX_OUT,
  output logic TX_OE,
  output logic TX_INT_REQ
);
  // Elaboration-time refusal of widths the divisor map cannot serve
  if (DIV_W != 8) begin : g_bad_width
    $error("Baud generator width must be 8");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  ast_pkg::ast_ctrl_s ctrl;
  logic port_enable;
  logic tx_interrupt_enable;
  logic tx_buffer_empty_flag;
  logic [7:0] transmit_buffer;
  logic buffer_full;
  logic [DIV_W-1:0] baud_divisor;
  logic [DIV_W-1:0] baud_count;
  logic [5:0] prescale;
  logic bit_tick;
  ast_pkg::ast_state_e state;
  logic [8:0] tx_shift_register;
  logic [3:0] bit_count;
  logic shifter_empty_status;
  logic active;
  logic run;
  logic wr_buffer;
  logic wr_ctrl;
  logic wr_divisor;
  logic enable_rise;
  logic load_now;
  logic [5:0] ticks_per_bit;
  logic [3:0] data_bits;

  // Only the asynchronous transmitter path exists here
  assign active = ctrl.transmit_enable & port_enable
                & ~ctrl.sync_select;
  assign run = active & ~SLEEP;
  assign wr_buffer = WR & hit(ADDR, ast_pkg::OFS_TX_BUFFER);
  assign wr_ctrl = WR & hit(ADDR, ast_pkg::OFS_TX_STATUS_CONTROL);
  assign wr_divisor = WR & hit(ADDR, ast_pkg::OFS_BAUD_DIVISOR);
  assign enable_rise = wr_ctrl & ~ctrl.transmit_enable
                     & WDATA[ast_pkg::BIT_TRANSMIT_ENABLE];
  assign ticks_per_bit = ctrl.high_speed_select ? ast_pkg::TICKS_HIGH_SPEED
                       : ast_pkg::TICKS_LOW_SPEED;
  assign data_bits = ctrl.nine_bit_select ? ast_pkg::BITS_NINE
                   : ast_pkg::BITS_EIGHT;
  // Transfer when shifter empty, or right at the stop bit's end
  assign load_now = run & buffer_full
                  & ((state == ast_pkg::ST_IDLE)
                  | ((state == ast_pkg::ST_STOP) & bit_tick));

  // Control registers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl <= '0;
      port_enable <= 1'b0;
      tx_interrupt_enable <= 1'b0;
      baud_divisor <= ast_pkg::RST_BAUD_DIVISOR;
    end else if (WR) begin
      if (hit(ADDR, ast_pkg::OFS_TX_STATUS_CONTROL)) begin
        ctrl.clock_source <= WDATA[ast_pkg::BIT_CLOCK_SOURCE];
        ctrl.nine_bit_select <= WDATA[ast_pkg::BIT_NINE_BIT_SELECT];
        ctrl.transmit_enable <= WDATA[ast_pkg::BIT_TRANSMIT_ENABLE];
        ctrl.sync_select <= WDATA[ast_pkg::BIT_SYNC_SELECT];
        ctrl.high_speed_select <= WDATA[ast_pkg::BIT_HIGH_SPEED_SELECT];
        ctrl.ninth_data_bit <= WDATA[ast_pkg::BIT_NINTH_DATA_BIT];
      end
      if (hit(ADDR, ast_pkg::OFS_PORT_CTRL)) begin
        port_enable <= WDATA[ast_pkg::BIT_PORT_ENABLE];
      end
      if (hit(ADDR, ast_pkg::OFS_ENABLES)) begin
        tx_interrupt_enable <= WDATA[ast_pkg::BIT_TX_INTERRUPT_ENABLE];
      end
      if (wr_divisor) begin
        baud_divisor <= WDATA[DIV_W-1:0];
      end
    end
  end

  // Transmit buffer, one deep; a write over unsent data replaces it
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      transmit_buffer <= ast_pkg::RST_TX_BUFFER;
      buffer_full <= 1'b0;
    end else if (wr_buffer) begin
      transmit_buffer <= WDATA;
      buffer_full <= 1'b1;
    end else if (load_now) begin
      buffer_full <= 1'b0;
    end
  end

  // Buffer empty flag: a buffer write in the transfer cycle leaves data
  // in the buffer, so the clear wins there on purpose
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_buffer_empty_flag <= 1'b0;
    end else if (wr_buffer) begin
      tx_buffer_empty_flag <= 1'b0;
    end else if (load_now) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (enable_rise & ~buffer_full) begin
      tx_buffer_empty_flag <= 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_INT_REQ <= 1'b0;
    end else begin
      TX_INT_REQ <= tx_buffer_empty_flag & tx_interrupt_enable;
    end
  end

  // Baud generator: reload counter then 16 or 64 ticks per bit
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      baud_count <= '0;
      prescale <= '0;
      bit_tick <= 1'b0;
    end else if (wr_divisor) begin
      baud_count <= '0;
      prescale <= '0;
      bit_tick <= 1'b0;
    end else if (SLEEP) begin
      // Hold a pending tick so the frozen sequencer still sees it on wake
      bit_tick <= bit_tick;
    end else if (baud_count == '0) begin
      baud_count <= baud_divisor;
      if (prescale >= ticks_per_bit) begin
        prescale <= '0;
        bit_tick <= 1'b1;
      end else begin
        prescale <= prescale + 6'h01;
        bit_tick <= 1'b0;
      end
    end else begin
      baud_count <= baud_count - 8'h01;
      bit_tick <= 1'b0;
    end
  end

  // Frame sequencer; the shifter is never visible on the bus
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ast_pkg::ST_IDLE;
      tx_shift_register <= '0;
      bit_count <= '0;
      TX_OUT <= 1'b1;
      shifter_empty_status <= 1'b1;
    end else if (!active) begin
      state <= ast_pkg::ST_IDLE;
      bit_count <= '0;
      TX_OUT <= 1'b1;
      shifter_empty_status <= 1'b1;
    end else if (!SLEEP) begin
      case (state)
        ast_pkg::ST_IDLE: begin
          TX_OUT <= 1'b1;
          if (load_now) begin
            tx_shift_register <= {ctrl.ninth_data_bit,
                                  transmit_buffer};
            shifter_empty_status <= 1'b0;
            state <= ast_pkg::ST_WAIT;
          end
        end
        ast_pkg::ST_WAIT: begin
          if (bit_tick) begin
            TX_OUT <= 1'b0;
            state <= ast_pkg::ST_START;
          end
        end
        ast_pkg::ST_START: begin
          if (bit_tick) begin
            TX_OUT <= tx_shift_register[0];
            tx_shift_register <= {1'b0, tx_shift_register[8:1]};
            bit_count <= 4'h1;
            state <= ast_pkg::ST_DATA;
          end
        end
        ast_pkg::ST_DATA: begin
          if (bit_tick) begin
            if (bit_count == data_bits) begin
              TX_OUT <= 1'b1;
              state <= ast_pkg::ST_STOP;
            end else begin
              TX_OUT <= tx_shift_register[0];
              tx_shift_register <= {1'b0, tx_shift_register[8:1]};
              bit_count <= bit_count + 4'h1;
            end
          end
        end
        ast_pkg::ST_STOP: begin
          if (bit_tick) begin
            if (load_now) begin
              // Back to back: start bit follows the stop bit directly
              tx_shift_register <= {ctrl.ninth_data_bit,
                                    transmit_buffer};
              TX_OUT <= 1'b0;
              state <= ast_pkg::ST_START;
            end else begin
              shifter_empty_status <= 1'b1;
              state <= ast_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= ast_pkg::ST_IDLE;
          TX_OUT <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_OE <= 1'b0;
    end else begin
      TX_OE <= active;
    end
  end

  // Read port: data valid the cycle after the strobe
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        ast_pkg::OFS_TX_STATUS_CONTROL: begin
          RDATA <= {ctrl.clock_source, ctrl.nine_bit_select,
                    ctrl.transmit_enable, ctrl.sync_select, 1'b0,
                    ctrl.high_speed_select, shifter_empty_status,
                    ctrl.ninth_data_bit};
        end
        ast_pkg::OFS_PORT_CTRL: begin
          RDATA <= {port_enable, 7'h00};
        end
        ast_pkg::OFS_TX_BUFFER: begin
          RDATA <= transmit_buffer;
        end
        ast_pkg::OFS_BAUD_DIVISOR: begin
          RDATA <= baud_divisor;
        end
        ast_pkg::OFS_FLAGS: begin
          RDATA <= {3'h0, tx_buffer_empty_flag, 4'h0};
        end
        ast_pkg::OFS_ENABLES: begin
          RDATA <= {3'h0, tx_interrupt_enable, 4'h0};
        end
        default: begin
          RDATA <= 8'h00;
        end
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### tb/ast_transmitter_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ast_transmitter_monitor (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SLEEP,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic TX_OUT,
  input wire logic TX_OE,
  input wire logic TX_INT_REQ
);
  logic [17:0] low_run;
  logic [17:0] high_run;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Runs freeze in sleep so a paused bit still counts as one whole bit
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      low_run <= 18'h00000;
      high_run <= 18'h00000;
    end else if (!SLEEP) begin
      low_run <= TX_OUT ? 18'h00000 : low_run + 18'h00001;
      high_run <= TX_OUT ? high_run + 18'h00001 : 18'h00000;
    end
  end
  property p_idle_high;
    !TX_OE |-> TX_OUT;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high");
  property p_abort;
    WR && ADDR == ast_pkg::OFS_TX_STATUS_CONTROL && !WDATA[5]
      |=> ##1 (TX_OUT && !TX_OE);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not clean");
  property p_int_mask;
    WR && ADDR == ast_pkg::OFS_ENABLES && !WDATA[4] |-> ##2 !TX_INT_REQ;
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("irq unmasked");
  property p_flag_clear;
    $fell(TX_INT_REQ) |-> $past(WR) || $past(WR, 2);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag fell");
  // Low stretches are whole bits, and every bit is a multiple of 16 cycles
  property p_bit_len;
    $rose(TX_OUT) && !$past(WR, 2) |-> low_run[3:0] == 4'h0;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit length");
  property p_stop_bit;
    $fell(TX_OUT) |-> high_run >= 18'h00010;
  endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("short stop");
  property p_sleep_hold;
    SLEEP && $past(SLEEP) && !$past(WR, 2) |-> $stable(TX_OUT);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("moved asleep");
  property p_unmapped;
    RD && ADDR == 8'h00 |=> RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  c_start: cover property ($fell(TX_OUT));
  c_irq: cover property ($rose(TX_INT_REQ));
  c_abort: cover property ($fell(TX_OE));
endmodule
bind ast_transmitter ast_transmitter_monitor u_mon (
  .CLK(CLK), .SYS_RST(SYS_RST), .SLEEP(SLEEP), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .TX_OUT(TX_OUT), .TX_OE(TX_OE),
  .TX_INT_REQ(TX_INT_REQ));
`default_nettype wire

// ### tb/ast_line_receiver.sv
`timescale 1ns/1ps
`default_nettype none
// Far end; samples mid-bit at the rate it is told, like a real receiver
module ast_line_receiver (
  input wire logic clk,
  input wire logic line,
  input wire logic nine,
  input wire logic [15:0] bit_cyc,
  output logic [8:0] data,
  output int frames,
  output int ferr
);
  logic [8:0] d;
  initial begin
    frames = 0;
    ferr = 0;
    data = 9'h000;
    forever begin
      @(negedge line);
      repeat (bit_cyc / 2) @(posedge clk);
      d = 9'h000;
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (bit_cyc) @(posedge clk);
        d[i] = line;
      end
      repeat (bit_cyc) @(posedge clk);
      if (!line) ferr++;
      data = d;
      frames++;
    end
  end
endmodule
`default_nettype wire

// ### tb/ast_transmitter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ast_transmitter_tb_top;
  typedef struct packed {
    logic [7:0] div;
    logic hs;
    logic nb;
    logic b9;
    logic [7:0] dat;
  } ast_row_s;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic SLEEP = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic TX_OUT;
  logic TX_OE;
  logic TX_INT_REQ;
  logic line;
  logic nine = 1'b0;
  logic [15:0] bit_cyc = 16'h0020;
  logic [8:0] rx_data;
  logic [7:0] rv;
  logic keep;
  int frames;
  int ferr;
  int cyc = 0;
  int t0;
  int n_errors = 0;
  int compares = 0;
  ast_row_s rows [4] = '{'{8'h01, 1'b1, 1'b0, 1'b0, 8'ha5},
    '{8'h00, 1'b0, 1'b0, 1'b0, 8'h3c}, '{8'h00, 1'b1, 1'b1, 1'b1, 8'h81},
    '{8'h02, 1'b1, 1'b1, 1'b0, 8'h7e}};
  // Released pin is pulled high, as on the board
  assign line = TX_OE ? TX_OUT : 1'b1;
  always #2 CLK = ~CLK;
  always @(posedge CLK) cyc++;
  ast_transmitter u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .SLEEP(SLEEP),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .TX_OUT(TX_OUT), .TX_OE(TX_OE), .TX_INT_REQ(TX_INT_REQ));
  ast_line_receiver u_rx (.clk(CLK), .line(line), .nine(nine),
    .bit_cyc(bit_cyc), .data(rx_data), .frames(frames), .ferr(ferr));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_frames(input int n);
    int f0;
    f0 = frames;
    for (int i = 0; i < 20000 && frames < f0 + n; i++) @(posedge CLK);
    cmp("frames", 16'(f0 + n), 16'(frames));
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge CLK);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge CLK);
    SYS_RST <= 1'b0;
    cmp("oe", 16'h0000, {15'h0000, TX_OE});
    rd(ast_pkg::OFS_TX_STATUS_CONTROL);
    cmp("ctrl", 16'h0002, {8'h00, rv});
    rd(8'h00);
    cmp("unmapped", 16'h0000, {8'h00, rv});
    wr(ast_pkg::OFS_PORT_CTRL, 8'h80);
    wr(ast_pkg::OFS_ENABLES, 8'h10);
    foreach (rows[i]) begin
      wr(ast_pkg::OFS_BAUD_DIVISOR, rows[i].div);
      bit_cyc <= 16'((rows[i].div + 1) * (rows[i].hs ? 16 : 64));
      nine <= rows[i].nb;
      rv = {1'b0, rows[i].nb, 1'b1, 2'b00, rows[i].hs, 1'b0, rows[i].b9};
      wr(ast_pkg::OFS_TX_STATUS_CONTROL, rv);
      rd(ast_pkg::OFS_FLAGS);
      cmp("flag", 16'h0010, {8'h00, rv & 8'h10});
      wr(ast_pkg::OFS_TX_BUFFER, rows[i].dat);
      wait_frames(1);
      cmp("rx", {7'h00, rows[i].nb & rows[i].b9, rows[i].dat}, rx_data);
      cmp("irq", 16'h0001, {15'h0000, TX_INT_REQ});
    end
    cmp("ferr", 16'h0000, 16'(ferr));
    // Let the last stop bit end so the shifter is empty again
    repeat (bit_cyc) @(posedge CLK);
    wr(ast_pkg::OFS_TX_BUFFER, 8'h5a);
    wr(ast_pkg::OFS_TX_BUFFER, 8'hc3);
    wait_frames(1);
    t0 = cyc;
    wait_frames(1);
    cmp("gap", 16'(11 * bit_cyc), 16'(cyc - t0));
    cmp("rx2", 16'h00c3, rx_data);
    wr(ast_pkg::OFS_ENABLES, 8'h00);
    repeat (2) @(posedge CLK);
    #1 cmp("mask", 16'h0000, {15'h0000, TX_INT_REQ});
    wr(ast_pkg::OFS_ENABLES, 8'h10);
    t0 = frames;
    wr(ast_pkg::OFS_TX_STATUS_CONTROL, 8'h30);
    wr(ast_pkg::OFS_TX_BUFFER, 8'h11);
    repeat (2000) @(posedge CLK);
    cmp("sync", 16'(t0), 16'(frames));
    t0 = frames;
    wr(ast_pkg::OFS_TX_STATUS_CONTROL, 8'h64);
    wait_frames(1);
    cmp("rx3", 16'h0011, rx_data);
    wr(ast_pkg::OFS_TX_BUFFER, 8'hf0);
    repeat (200) @(posedge CLK);
    wr(ast_pkg::OFS_TX_STATUS_CONTROL, 8'h44);
    repeat (2) @(posedge CLK);
    #1 cmp("abort", 16'h0000, {15'h0000, TX_OE});
    wr(ast_pkg::OFS_TX_STATUS_CONTROL, 8'h64);
    repeat (600) @(posedge CLK);
    wr(ast_pkg::OFS_TX_BUFFER, 8'h0f);
    repeat (150) @(posedge CLK);
    SLEEP <= 1'b1;
    repeat (2) @(posedge CLK);
    keep = TX_OUT;
    repeat (300) @(posedge CLK);
    cmp("sleep", {15'h0000, keep}, {15'h0000, TX_OUT});
    SLEEP <= 1'b0;
    report_and_stop();
  end
endmodule
`default_nettype wire
